// ==== hw/adc_seq_pkg.sv ====
`default_nettype none

package adc_seq_pkg;

  // ----------------------------------------------------------------
  // converter geometry
  // ----------------------------------------------------------------
  localparam int unsigned NUM_CH     = 8;
  localparam int unsigned CH_PER_CNV = 4;
  localparam int unsigned RES_W      = 12;
  localparam int unsigned WORD_W     = 16;
  localparam int unsigned HALF_W     = 16;
  localparam int unsigned ENTRY_W    = 2 * HALF_W + 1;

  // ----------------------------------------------------------------
  // timing: clock rates in Hz, divider minimum, counts in converter clock cycles (FIRST_HALF_CLKS in half cycles)
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ          = 100_000_000;
  localparam int unsigned CONV_MAX_HZ     = 5_330_000;
  localparam int unsigned FIRST_HALF_CLKS = 17;
  localparam int unsigned NEXT_CONV_CLKS  = 6;
  localparam int unsigned WAKE_CONV_CLKS  = 1;
  localparam logic [7:0]  DIV_MIN         = 8'h02;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W         = 8;
  localparam logic [7:0]  OFS_CTRL       = 8'h00;
  localparam logic [7:0]  OFS_CHCFG      = 8'h04;
  localparam logic [7:0]  OFS_OFFSET     = 8'h08;
  localparam logic [7:0]  OFS_LIMIT      = 8'h0C;
  localparam logic [7:0]  OFS_IRQCFG     = 8'h10;
  localparam logic [7:0]  OFS_STATUS     = 8'h14;
  localparam logic [7:0]  OFS_RESULT     = 8'h20;
  localparam logic [7:0]  OFS_RESULT_END = 8'h5C;

  localparam int unsigned CTRL_EN      = 0;
  localparam int unsigned CTRL_MODE    = 1;
  localparam int unsigned CTRL_LOOP    = 3;
  localparam int unsigned CTRL_START   = 4;
  localparam int unsigned CTRL_SIGNED  = 5;
  localparam int unsigned CTRL_CORR    = 6;
  localparam int unsigned CTRL_PSAVE   = 7;
  localparam int unsigned CTRL_FREEZE  = 8;
  localparam int unsigned CTRL_DIV     = 16;
  localparam int unsigned CHCFG_ACTIVE = 0;
  localparam int unsigned CHCFG_DIFF   = 8;
  localparam int unsigned CHCFG_SINGLE = 16;
  localparam int unsigned STAT_DONE    = 3;

  localparam logic [7:0]  DIV_RST    = 8'h07;
  localparam logic [7:0]  ACTIVE_RST = 8'hFF;
  localparam logic [11:0] MID_SCALE  = 12'h800;
  localparam logic [1:0]  RESP_OKAY  = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    MODE_SINGLE = 2'h0,
    MODE_SEQ    = 2'h1,
    MODE_SIMUL  = 2'h2
  } scan_mode_t;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'h0,
    ST_PWRUP = 2'h1,
    ST_CONV  = 2'h3
  } seq_state_t;

endpackage

`default_nettype wire

// ==== hw/dual_adc_scan_sequencer.sv ====
`timescale 1ns/1ps
`default_nettype none

module sample_fifo
  #(
    parameter int unsigned WIDTH = 33,
    parameter int unsigned DEPTH = 4
  )
  (
    input  wire logic             aclk,
    input  wire logic             aresetn,
    input  wire logic [WIDTH-1:0] in_data,
    input  wire logic             in_valid,
    output logic                  in_ready,
    output logic [WIDTH-1:0]      out_data,
    output logic                  out_valid,
    input  wire logic             out_ready
  );

  localparam int unsigned AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wptr;
    logic [AW-1:0]               rptr;
    logic [AW:0]                 count;
  } fifo_regs_t;

  fifo_regs_t r_ff;
  fifo_regs_t nxt_r;
  logic       push;
  logic       pop;

  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
  begin : g_bad_depth
    $error("fifo depth must be a power of two of at least 2");
  end

  assign in_ready  = (r_ff.count != (AW+1)'(DEPTH));
  assign out_valid = (r_ff.count != '0);
  assign out_data  = r_ff.mem[r_ff.rptr];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb
  begin
    nxt_r = r_ff;
    if (push)
    begin
      nxt_r.mem[r_ff.wptr] = in_data;
      nxt_r.wptr           = r_ff.wptr + 1'b1;
    end
    if (pop)
      nxt_r.rptr = r_ff.rptr + 1'b1;
    case ({push, pop})
      2'b10:   nxt_r.count = r_ff.count + 1'b1;
      2'b01:   nxt_r.count = r_ff.count - 1'b1;
      default: nxt_r.count = r_ff.count;
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      r_ff <= '0;
    else
      r_ff <= nxt_r;
  end

endmodule

module dual_adc_scan_sequencer
  import adc_seq_pkg::*;
  #(
    parameter int unsigned FIFO_DEPTH = 4
  )
  (
    input  wire logic              aclk,
    input  wire logic              aresetn,
    input  wire logic [ADDR_W-1:0] awaddr,
    input  wire logic              awvalid,
    output logic                   awready,
    input  wire logic [31:0]       wdata,
    input  wire logic [3:0]        wstrb,
    input  wire logic              wvalid,
    output logic                   wready,
    output logic [1:0]             bresp,
    output logic                   bvalid,
    input  wire logic              bready,
    input  wire logic [ADDR_W-1:0] araddr,
    input  wire logic              arvalid,
    output logic                   arready,
    output logic [31:0]            rdata,
    output logic [1:0]             rresp,
    output logic                   rvalid,
    input  wire logic              rready,
    output logic                   conv_clk,
    output logic                   conv_sample_a,
    output logic                   conv_sample_b,
    output logic [1:0]             conv_sel_a,
    output logic [1:0]             conv_sel_b,
    output logic                   conv_diff_a,
    output logic                   conv_diff_b,
    output logic                   conv_pwr_a,
    output logic                   conv_pwr_b,
    input  wire logic [RES_W-1:0]  conv_data_a,
    input  wire logic [RES_W-1:0]  conv_data_b,
    output logic                   irq
  );

  if (FIFO_DEPTH < 2 || NUM_CH != 2 * CH_PER_CNV)
  begin : g_bad_cfg
    $error("unsupported fifo depth or channel count");
  end

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic                          awready;
    logic                          wready;
    logic                          aw_got;
    logic                          w_got;
    logic [ADDR_W-1:0]             awaddr;
    logic [31:0]                   wdata;
    logic [3:0]                    wstrb;
    logic                          bvalid;
    logic [1:0]                    bresp;
    logic                          arready;
    logic                          rvalid;
    logic [1:0]                    rresp;
    logic [31:0]                   rdata;
    logic                          en;
    scan_mode_t                    mode;
    logic                          loop;
    logic                          sgn;
    logic                          corr;
    logic                          psave;
    logic                          freeze;
    logic [7:0]                    div;
    logic [NUM_CH-1:0]             active;
    logic [NUM_CH-1:0]             diff;
    logic [2:0]                    single_ch;
    logic [RES_W-1:0]              offset;
    logic [WORD_W-1:0]             lim_lo;
    logic [WORD_W-1:0]             lim_hi;
    logic [2:0]                    irq_en;
    logic [2:0]                    stat;
    logic                          done;
    logic [2:0]                    pend;
    logic                          irq;
    logic [7:0]                    divcnt;
    logic                          conv_clk;
    seq_state_t                    st;
    logic [2:0]                    idx;
    logic [15:0]                   tmr;
    logic                          sample_a;
    logic                          sample_b;
    logic [1:0]                    sel;
    logic                          diff_a;
    logic                          diff_b;
    logic                          pwr_a;
    logic                          pwr_b;
    logic                          push;
    logic [ENTRY_W-1:0]            entry;
    logic [NUM_CH-1:0]             seen;
    logic [NUM_CH-1:0][WORD_W-1:0] res;
  } regs_t;

  regs_t              r_ff;
  regs_t              nxt_r;
  logic [7:0]         eff_div;
  logic [15:0]        first_cyc;
  logic [15:0]        next_cyc;
  logic [31:0]        wmask;
  logic [31:0]        wmerged;
  logic [32:0]        rview;
  logic               start_req;
  logic [2:0]         stat_clr;
  logic               done_clr;
  logic [3:0]         pk;
  logic               do_launch;
  logic               launch_long;
  logic [2:0]         launch_idx;
  logic [2:0]         pend_new;
  logic               fifo_in_ready;
  logic               fifo_out_valid;
  logic [ENTRY_W-1:0] fifo_out_data;
  logic [1:0]         h_v;
  logic [1:0][2:0]    h_ch;
  logic [1:0][15:0]   h_word;
  logic [1:0][2:0]    h_flag;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // lowest scan position at or after from; bit 3 says one was found
  function automatic logic [3:0] pick(input logic [7:0] act,
                                      input scan_mode_t md,
                                      input logic [3:0] from);
    logic [3:0] p;
    p = 4'h0;
    for (int i = 7; i >= 0; i--)
    begin
      if (4'(i) >= from && ((md == MODE_SIMUL) ?
          (i < 4 && (act[i] || act[(i + 4) % 8])) : act[i]))
        p = {1'b1, 3'(i)};
    end
    return p;
  endfunction

  // register read view; bit 32 flags a mapped address
  function automatic logic [32:0] reg_view(input regs_t s,
                                           input logic [7:0] a);
    logic [32:0] v;
    logic [7:0]  wa;
    logic [3:0]  slot;
    wa   = {a[7:2], 2'b00};
    slot = 4'((wa - OFS_RESULT) >> 2);
    v    = {1'b1, 32'h0};
    case (wa)
      OFS_CTRL:   v[31:0] = {8'h00, s.div, 7'h00, s.freeze, s.psave,
                             s.corr, s.sgn, 1'b0, s.loop, s.mode, s.en};
      OFS_CHCFG:  v[31:0] = {13'h0000, s.single_ch, s.diff, s.active};
      OFS_OFFSET: v[31:0] = {20'h00000, s.offset};
      OFS_LIMIT:  v[31:0] = {s.lim_hi, s.lim_lo};
      OFS_IRQCFG: v[31:0] = {29'h00000000, s.irq_en};
      OFS_STATUS: v[31:0] = {26'h0000000, s.irq, s.st != ST_IDLE,
                             s.done, s.stat};
      default:
        if (wa >= OFS_RESULT && wa <= OFS_RESULT_END)
          v[31:0] = slot[3] ? 32'h0 : {16'h0000, s.res[slot[2:0]]};
        else
          v = 33'h0;
    endcase
    return v;
  endfunction

  // ----------------------------------------------------------------
  // result shaping per half of a fifo entry
  // ----------------------------------------------------------------
  for (genvar h = 0; h < 2; h++)
  begin : g_half
    logic [RES_W-1:0] d;
    logic [RES_W-1:0] c;
    logic             sc;
    assign h_v[h]  = fifo_out_data[h*HALF_W + 15];
    assign h_ch[h] = fifo_out_data[h*HALF_W + 12 +: 3];
    assign d       = fifo_out_data[h*HALF_W +: RES_W];
    assign c = !r_ff.corr ? d :
               (d < r_ff.offset) ? '0 : d - r_ff.offset;
    assign sc = r_ff.sgn || r_ff.diff[h_ch[h]];
    assign h_word[h] = {(sc ? c ^ MID_SCALE : c), 4'h0};
    assign h_flag[h][0] = sc ? $signed(h_word[h]) > $signed(r_ff.lim_hi)
                             : h_word[h] > r_ff.lim_hi;
    assign h_flag[h][1] = sc ? $signed(h_word[h]) < $signed(r_ff.lim_lo)
                             : h_word[h] < r_ff.lim_lo;
    assign h_flag[h][2] = sc && r_ff.seen[h_ch[h]] &&
                          (h_word[h][15] != r_ff.res[h_ch[h]][15]);
  end

  sample_fifo
    #(
      .WIDTH (ENTRY_W),
      .DEPTH (FIFO_DEPTH)
    )
    u_fifo
    (
      .aclk      (aclk),
      .aresetn   (aresetn),
      .in_data   (r_ff.entry),
      .in_valid  (r_ff.push),
      .in_ready  (fifo_in_ready),
      .out_data  (fifo_out_data),
      .out_valid (fifo_out_valid),
      .out_ready (!r_ff.freeze)
    );

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    nxt_r        = r_ff;
    start_req    = 1'b0;
    stat_clr     = 3'h0;
    done_clr     = 1'b0;
    wmask        = 32'h0;
    wmerged      = 32'h0;
    rview        = 33'h0;
    pk           = 4'h0;
    do_launch    = 1'b0;
    launch_long  = 1'b0;
    launch_idx   = 3'h0;
    pend_new     = r_ff.pend;
    nxt_r.sample_a = 1'b0;
    nxt_r.sample_b = 1'b0;

    // converter clock from the system clock
    eff_div   = (r_ff.div < DIV_MIN) ? DIV_MIN : r_ff.div;
    nxt_r.divcnt = (r_ff.divcnt >= eff_div - 8'h01) ? 8'h00
                                                   : r_ff.divcnt + 8'h01;
    nxt_r.conv_clk = nxt_r.divcnt < (eff_div >> 1);
    first_cyc = 16'((32'(eff_div) * FIRST_HALF_CLKS + 32'd1) >> 1);
    next_cyc  = 16'(32'(eff_div) * NEXT_CONV_CLKS);

    // register writes
    if (awvalid && r_ff.awready)
    begin
      nxt_r.aw_got = 1'b1;
      nxt_r.awaddr = awaddr;
    end
    if (wvalid && r_ff.wready)
    begin
      nxt_r.w_got = 1'b1;
      nxt_r.wdata = wdata;
      nxt_r.wstrb = wstrb;
    end
    if (r_ff.bvalid && bready)
      nxt_r.bvalid = 1'b0;
    if (r_ff.aw_got && r_ff.w_got && !r_ff.bvalid)
    begin
      nxt_r.aw_got = 1'b0;
      nxt_r.w_got  = 1'b0;
      nxt_r.bvalid = 1'b1;
      nxt_r.bresp  = RESP_OKAY;
      for (int b = 0; b < 4; b++)
        wmask[b*8 +: 8] = {8{r_ff.wstrb[b]}};
      rview   = reg_view(r_ff, r_ff.awaddr);
      wmerged = (rview[31:0] & ~wmask) | (r_ff.wdata & wmask);
      case ({r_ff.awaddr[7:2], 2'b00})
        OFS_CTRL:
        begin
          nxt_r.en     = wmerged[CTRL_EN];
          nxt_r.mode   = scan_mode_t'(wmerged[CTRL_MODE +: 2]);
          nxt_r.loop   = wmerged[CTRL_LOOP];
          start_req    = wmerged[CTRL_START];
          nxt_r.sgn    = wmerged[CTRL_SIGNED];
          nxt_r.corr   = wmerged[CTRL_CORR];
          nxt_r.psave  = wmerged[CTRL_PSAVE];
          nxt_r.freeze = wmerged[CTRL_FREEZE];
          nxt_r.div    = wmerged[CTRL_DIV +: 8];
        end
        OFS_CHCFG:
        begin
          nxt_r.active    = wmerged[CHCFG_ACTIVE +: NUM_CH];
          nxt_r.diff      = wmerged[CHCFG_DIFF +: NUM_CH];
          nxt_r.single_ch = wmerged[CHCFG_SINGLE +: 3];
        end
        OFS_OFFSET: nxt_r.offset = wmerged[RES_W-1:0];
        OFS_LIMIT:
        begin
          nxt_r.lim_lo = wmerged[15:0];
          nxt_r.lim_hi = wmerged[31:16];
        end
        OFS_IRQCFG: nxt_r.irq_en = wmerged[2:0];
        OFS_STATUS:
        begin
          stat_clr = r_ff.wdata[2:0] & wmask[2:0];
          done_clr = r_ff.wdata[STAT_DONE] & wmask[STAT_DONE];
        end
        default:
          if (!rview[32])
            nxt_r.bresp = RESP_SLVERR;
      endcase
    end
    nxt_r.awready = !nxt_r.aw_got && !nxt_r.bvalid;
    nxt_r.wready  = !nxt_r.w_got && !nxt_r.bvalid;

    // register reads
    if (r_ff.rvalid && rready)
      nxt_r.rvalid = 1'b0;
    if (arvalid && r_ff.arready)
    begin
      rview        = reg_view(r_ff, araddr);
      nxt_r.rdata  = rview[31:0];
      nxt_r.rresp  = rview[32] ? RESP_OKAY : RESP_SLVERR;
      nxt_r.rvalid = 1'b1;
    end
    nxt_r.arready = !nxt_r.rvalid;

    // scan sequencer
    if (r_ff.push && fifo_in_ready)
      nxt_r.push = 1'b0;
    case (r_ff.st)
      ST_IDLE:
        if (r_ff.en && (start_req || r_ff.loop))
        begin
          pk = (r_ff.mode == MODE_SINGLE) ? {1'b1, r_ff.single_ch}
                                          : pick(r_ff.active, r_ff.mode, 4'h0);
          if (pk[3] && r_ff.psave)
          begin
            nxt_r.st  = ST_PWRUP;
            nxt_r.idx = pk[2:0];
            nxt_r.tmr = 16'(32'(eff_div) * WAKE_CONV_CLKS);
          end
          else if (pk[3])
          begin
            do_launch   = 1'b1;
            launch_long = 1'b1;
            launch_idx  = pk[2:0];
          end
        end
      ST_PWRUP:
        if (r_ff.tmr > 16'h0001)
          nxt_r.tmr = r_ff.tmr - 16'h0001;
        else
        begin
          do_launch   = 1'b1;
          launch_long = 1'b1;
          launch_idx  = r_ff.idx;
        end
      ST_CONV:
        if (r_ff.tmr > 16'h0001)
          nxt_r.tmr = r_ff.tmr - 16'h0001;
        else if (!r_ff.push || fifo_in_ready)
        begin
          pk = (r_ff.mode == MODE_SINGLE) ? 4'h0 :
               pick(r_ff.active, r_ff.mode, {1'b0, r_ff.idx} + 4'h1);
          if (!pk[3] && r_ff.en && r_ff.loop && r_ff.mode != MODE_SINGLE)
            pk = pick(r_ff.active, r_ff.mode, 4'h0);
          nxt_r.push  = 1'b1;
          nxt_r.entry = {!pk[3] || pk[2:0] <= r_ff.idx,
                         (r_ff.mode == MODE_SIMUL) ?
                           r_ff.active[{1'b1, r_ff.idx[1:0]}] : r_ff.idx[2],
                         1'b1, r_ff.idx[1:0], conv_data_b,
                         (r_ff.mode == MODE_SIMUL) ?
                           r_ff.active[{1'b0, r_ff.idx[1:0]}] : !r_ff.idx[2],
                         1'b0, r_ff.idx[1:0], conv_data_a};
          if (pk[3])
          begin
            do_launch  = 1'b1;
            launch_idx = pk[2:0];
          end
          else
            nxt_r.st = ST_IDLE;
        end
      default: nxt_r.st = ST_IDLE;
    endcase
    if (do_launch)
    begin
      nxt_r.st       = ST_CONV;
      nxt_r.idx      = launch_idx;
      nxt_r.tmr      = launch_long ? first_cyc : next_cyc;
      nxt_r.sel      = launch_idx[1:0];
      nxt_r.diff_a   = r_ff.diff[{1'b0, launch_idx[1:0]}];
      nxt_r.diff_b   = r_ff.diff[{1'b1, launch_idx[1:0]}];
      nxt_r.sample_a = (r_ff.mode == MODE_SIMUL) || !launch_idx[2];
      nxt_r.sample_b = (r_ff.mode == MODE_SIMUL) || launch_idx[2];
    end
    if (!r_ff.en)
      nxt_r.st = ST_IDLE;

    // result store and end-of-scan events
    if (fifo_out_valid && !r_ff.freeze)
    begin
      for (int h = 0; h < 2; h++)
        if (h_v[h])
        begin
          nxt_r.res[h_ch[h]]  = h_word[h];
          nxt_r.seen[h_ch[h]] = 1'b1;
          pend_new = pend_new | h_flag[h];
        end
      nxt_r.pend = fifo_out_data[ENTRY_W-1] ? 3'h0 : pend_new;
    end
    nxt_r.stat = (r_ff.stat & ~stat_clr) |
                 ((fifo_out_valid && !r_ff.freeze &&
                   fifo_out_data[ENTRY_W-1]) ? pend_new : 3'h0);
    nxt_r.done = (r_ff.done && !done_clr) ||
                 (fifo_out_valid && !r_ff.freeze && fifo_out_data[ENTRY_W-1]);
    nxt_r.irq  = |(nxt_r.stat & nxt_r.irq_en);

    // converters powered only while in use under power saving
    nxt_r.pwr_a = nxt_r.en && (!nxt_r.psave || (nxt_r.st != ST_IDLE &&
                  ((nxt_r.mode == MODE_SINGLE) ? !nxt_r.single_ch[2]
                                               : |nxt_r.active[3:0])));
    nxt_r.pwr_b = nxt_r.en && (!nxt_r.psave || (nxt_r.st != ST_IDLE &&
                  ((nxt_r.mode == MODE_SINGLE) ? nxt_r.single_ch[2]
                                               : |nxt_r.active[7:4])));
    // both converters sample together in simultaneous mode
    if (nxt_r.mode == MODE_SIMUL)
    begin
      nxt_r.pwr_a = nxt_r.pwr_a || nxt_r.pwr_b;
      nxt_r.pwr_b = nxt_r.pwr_a;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      r_ff        <= '0;
      r_ff.div    <= DIV_RST;
      r_ff.active <= ACTIVE_RST;
    end
    else
      r_ff <= nxt_r;
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign awready       = r_ff.awready;
  assign wready        = r_ff.wready;
  assign bresp         = r_ff.bresp;
  assign bvalid        = r_ff.bvalid;
  assign arready       = r_ff.arready;
  assign rdata         = r_ff.rdata;
  assign rresp         = r_ff.rresp;
  assign rvalid        = r_ff.rvalid;
  assign conv_clk      = r_ff.conv_clk;
  assign conv_sample_a = r_ff.sample_a;
  assign conv_sample_b = r_ff.sample_b;
  assign conv_sel_a    = r_ff.sel;
  assign conv_sel_b    = r_ff.sel;
  assign conv_diff_a   = r_ff.diff_a;
  assign conv_diff_b   = r_ff.diff_b;
  assign conv_pwr_a    = r_ff.pwr_a;
  assign conv_pwr_b    = r_ff.pwr_b;
  assign irq           = r_ff.irq;

endmodule

`default_nettype wire

// ==== testbench/adc_seq_properties.sv ====
`timescale 1ns/1ps
`default_nettype none
module adc_seq_checker
  (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        awready,
  input wire logic        bvalid,
  input wire logic        arvalid,
  input wire logic        arready,
  input wire logic        rvalid,
  input wire logic        rready,
  input wire logic [31:0] rdata,
  input wire logic        conv_clk,
  input wire logic        conv_sample_a,
  input wire logic [1:0]  conv_sel_a,
  input wire logic [1:0]  conv_sel_b,
  input wire logic        conv_pwr_a,
  input wire logic        conv_sample_b,
  input wire logic        conv_pwr_b
  );
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  AST_SEL_PAIR: assert property (conv_sel_a == conv_sel_b)
    else $error("selects differ");
  AST_GAP: assert property (conv_sample_a |=> !conv_sample_a [*8])
    else $error("samples too close");
  AST_PWR: assert property (conv_sample_a |-> conv_pwr_a)
    else $error("sample while unpowered");
  AST_PWR_B: assert property (conv_sample_b |-> conv_pwr_b)
    else $error("sample while unpowered");
  AST_CLK: assert property ($rose(conv_clk) |-> ##[1:200] $fell(conv_clk))
    else $error("converter clock stuck");
  AST_RD: assert property (arvalid && arready |=> rvalid)
    else $error("no read answer");
  AST_RHOLD: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data dropped");
  AST_AW_LOW: assert property (bvalid |-> !awready)
    else $error("write taken early");
  AST_AR_LOW: assert property (rvalid |-> !arready)
    else $error("read taken early");
endmodule
bind dual_adc_scan_sequencer adc_seq_checker adc_seq_checker_i (
  .aclk(aclk), .aresetn(aresetn), .awready(awready), .bvalid(bvalid),
  .arvalid(arvalid), .arready(arready), .rvalid(rvalid), .rready(rready),
  .rdata(rdata), .conv_clk(conv_clk), .conv_sample_a(conv_sample_a),
  .conv_sel_a(conv_sel_a), .conv_sel_b(conv_sel_b), .conv_pwr_a(conv_pwr_a),
  .conv_sample_b(conv_sample_b), .conv_pwr_b(conv_pwr_b));
`default_nettype wire

// ==== testbench/adc_partner.sv ====
`timescale 1ns/1ps
`default_nettype none
module adc_partner
  import adc_seq_pkg::*;
  (
  input wire logic         aclk,
  input wire logic         sample_a,
  input wire logic         sample_b,
  input wire logic [1:0]   sel_a,
  input wire logic [1:0]   sel_b,
  input wire logic [3:0]   salt,
  output logic [RES_W-1:0] data_a,
  output logic [RES_W-1:0] data_b
  );
  // each converter answers with a code set by its channel and salt
  always_ff @(posedge aclk)
  begin
    if (sample_a)
      data_a <= 12'h100 + 12'h111 * {10'h0, sel_a} + {8'h0, salt};
    if (sample_b)
      data_b <= 12'h544 + 12'h111 * {10'h0, sel_b} + {8'h0, salt};
  end
endmodule
`default_nettype wire

// ==== testbench/dual_adc_scan_sequencer_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module dual_adc_scan_sequencer_tb
  import adc_seq_pkg::*;
  ;
  logic aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0;
  logic bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata;
  logic [3:0] salt = 4'h0;
  logic awready, wready, bvalid, arready, rvalid, sa, sb, irq;
  logic [1:0] bresp, rresp, sla, slb;
  logic [RES_W-1:0] da, db;
  int failures = 0, n_compared = 0;
  always #5 aclk = ~aclk;
  dual_adc_scan_sequencer dual_adc_scan_sequencer_i (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(4'hF), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready), .conv_clk(),
    .conv_sample_a(sa), .conv_sample_b(sb), .conv_sel_a(sla),
    .conv_sel_b(slb), .conv_diff_a(), .conv_diff_b(), .conv_pwr_a(),
    .conv_pwr_b(), .conv_data_a(da), .conv_data_b(db), .irq(irq));
  adc_partner adc_partner_i (.aclk(aclk), .sample_a(sa), .sample_b(sb),
    .sel_a(sla), .sel_b(slb), .salt(salt), .data_a(da), .data_b(db));
  task automatic stop_test;
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic cmp(input logic [33:0] g, input logic [33:0] e);
    n_compared++;
    if (g !== e)
    begin
      failures++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // one AXI4-Lite write (w=1) or read (w=0); d is write or expected data
  task automatic xfer(input bit w, input logic [7:0] a,
                      input logic [31:0] d, input logic [1:0] r);
    int n;
    bit aw_t, w_t, ar_t, dn;
    logic [33:0] g;
    @(posedge aclk);
    awaddr <= a;
    araddr <= a;
    wdata <= d;
    awvalid <= w;
    wvalid <= w;
    bready <= w;
    arvalid <= !w;
    // readies and answers are taken settled, before the edge that uses them
    for (n = 0; n < 99; n++)
    begin
      @(negedge aclk);
      aw_t = awready;
      w_t  = wready;
      ar_t = arready;
      dn   = w ? bvalid : rvalid && rready;
      g    = w ? {bresp, 32'h0} : {rresp, rdata};
      @(posedge aclk);
      if (aw_t) awvalid <= 1'b0;
      if (w_t) wvalid <= 1'b0;
      if (ar_t) arvalid <= 1'b0;
      // late rready lets the read answer wait one cycle
      if (n == 1) rready <= !w;
      if (dn) break;
    end
    bready <= 1'b0;
    rready <= 1'b0;
    cmp(g, {r, w ? 32'h0 : d});
    if (n == 99)
    begin
      failures++;
      stop_test();
    end
  endtask
  // result words of all eight channels after offset and sign flip
  task automatic chk(input logic [11:0] ofs, input logic [7:0] dm);
    logic [11:0] v;
    for (int c = 0; c < 8; c++)
    begin
      v = 12'h100 + 12'h111 * c[11:0] + {8'h0, salt} - ofs;
      xfer(0, OFS_RESULT + 8'(4 * c), {16'h0, v ^ {dm[c], 11'h0}, 4'h0}, RESP_OKAY);
    end
  endtask
  initial
  begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    xfer(0, OFS_CTRL, 32'h0007_0000, RESP_OKAY);
    xfer(0, OFS_CHCFG, 32'h0000_00FF, RESP_OKAY);
    xfer(0, 8'h40, 32'h0, RESP_OKAY);
    xfer(0, 8'hF0, 32'h0, RESP_SLVERR);
    xfer(1, 8'hF0, 32'h1, RESP_SLVERR);
    xfer(1, OFS_CTRL, 32'h0013_000B, RESP_OKAY);
    repeat (2500) @(posedge aclk);
    chk(12'h000, 8'h00);
    xfer(0, OFS_STATUS, 32'h0000_0019, RESP_OKAY);
    cmp({33'h0, irq}, 34'h0);
    xfer(1, OFS_IRQCFG, 32'h1, RESP_OKAY);
    cmp({33'h0, irq}, 34'h1);
    salt <= 4'h5;
    xfer(1, OFS_OFFSET, 32'h50, RESP_OKAY);
    xfer(1, OFS_CHCFG, 32'h02FF, RESP_OKAY);
    xfer(1, OFS_CTRL, 32'h0013_004B, RESP_OKAY);
    repeat (2500) @(posedge aclk);
    chk(12'h050, 8'h02);
    salt <= 4'h9;
    xfer(1, OFS_CTRL, 32'h0013_00CD, RESP_OKAY);
    repeat (2500) @(posedge aclk);
    chk(12'h050, 8'h02);
    stop_test();
  end
endmodule
`default_nettype wire
